//--- verification/cmc_pll_model.sv
`timescale 1ns/10ps
`default_nettype none
// Stands in for the loop: locks a set count after init, loses lock on upset.
module cmc_pll_model (
    input wire logic       clock,
    input wire logic       rstn,
    input wire logic       enable,
    input wire logic       init,
    input wire logic       upset,
    input wire logic [7:0] delay,
    output var logic       locked
);
    logic [7:0] cnt;
    // Lock is lost at once when disabled or upset by the bench.
    always @(posedge clock or negedge rstn) begin
        if (!rstn || !enable || upset) begin
            cnt <= 8'h00;
            locked <= 1'b0;
        end else if (init && cnt == delay) begin
            locked <= 1'b1;
        end else if (init) begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule
`default_nettype wire

//--- verification/cmc_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the multiplier control block at its ports.
module cmc_checker (
    input wire logic       clock,
    input wire logic       rstn,
    input wire logic       clk_en,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_page,
    input wire logic       sfr_wr,
    input wire logic       sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic       pll_lock,
    input wire logic [2:0] ext_osc_mode_field,
    input wire logic [7:0] sfr_rdata_reg,
    input wire logic       mult_enable_reg,
    input wire logic       pll_init_reg,
    input wire logic [1:0] mult_source_reg,
    input wire logic [2:0] mult_factor_reg,
    input wire logic [2:0] out_scale_reg,
    input wire logic       pad_p02_claim_reg,
    input wire logic       pad_p03_claim_reg
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // High when an access is aimed at the control register.
    logic hit;
    assign hit = clk_en && sfr_addr == 8'h97 && sfr_page == 8'h0F;
    sequence s_wr; hit && sfr_wr; endsequence
    sequence s_rd; hit && sfr_rd; endsequence
    property p_en; s_wr |=> mult_enable_reg == $past(sfr_wdata[7]); endproperty
    property p_src; s_wr |=> mult_source_reg == $past(sfr_wdata[1:0]); endproperty
    property p_scale;
        s_wr |=> out_scale_reg == ($past(sfr_wdata[1]) ? $past(sfr_wdata[4:2]) : 3'h0);
    endproperty
    property p_factor; mult_factor_reg == (mult_source_reg[1] ? 3'h4 : 3'h2); endproperty
    // Initialize starts on an enabling init write, or again after lock was lost.
    property p_init;
        $rose(pll_init_reg) |-> $past(mult_enable_reg)
            && ($past(hit && sfr_wr && sfr_wdata[6] && sfr_wdata[7]) || !$past(pll_lock));
    endproperty
    property p_rdy;
        s_rd ##1 sfr_rdata_reg[5] |-> ($past(pll_lock) || $past(pll_lock, 2)) && $past(mult_enable_reg);
    endproperty
    property p_rdy_off; s_rd ##0 (!mult_enable_reg && !$past(mult_enable_reg)) |=> !sfr_rdata_reg[5];
    endproperty
    property p_page;
        clk_en && sfr_wr && !hit |=> $stable(mult_enable_reg) && $stable(mult_source_reg);
    endproperty
    property p_xtal;
        clk_en |=> pad_p02_claim_reg == ($past(ext_osc_mode_field[2:1]) == 2'h3);
    endproperty
    property p_pin3; clk_en |=> pad_p03_claim_reg == ($past(ext_osc_mode_field) >= 3'h2);
    endproperty
    a_en: assert property (p_en) else $error("enable bit not taken");
    a_src: assert property (p_src) else $error("source field not taken");
    a_scale: assert property (p_scale) else $error("scaling output wrong");
    a_factor: assert property (p_factor) else $error("base factor wrong");
    a_init: assert property (p_init) else $error("init started without enable");
    a_rdy: assert property (p_rdy) else $error("ready read without lock");
    a_rdy_off: assert property (p_rdy_off) else $error("ready while disabled");
    a_page: assert property (p_page) else $error("foreign access changed state");
    a_xtal: assert property (p_xtal) else $error("two-pin claim wrong");
    a_pin3: assert property (p_pin3) else $error("output pad claim wrong");
endmodule
bind cmc_top cmc_checker cmc_checker_inst (.clock, .rstn, .clk_en, .sfr_addr, .sfr_page,
    .sfr_wr, .sfr_rd, .sfr_wdata, .pll_lock, .ext_osc_mode_field, .sfr_rdata_reg,
    .mult_enable_reg, .pll_init_reg, .mult_source_reg, .mult_factor_reg, .out_scale_reg,
    .pad_p02_claim_reg, .pad_p03_claim_reg);
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// Drives the control register and oscillator mode, checks every output.
module tb_top;
    logic clock = 1'b0, rstn = 1'b0, clk_en = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
    logic [7:0] sfr_addr = 8'h00, sfr_page = 8'h00, sfr_wdata = 8'h00, sfr_rdata_reg;
    logic [7:0] lock_dly = 8'h00, d;
    logic [2:0] ext_osc_mode_field = 3'h0, mult_factor_reg, out_scale_reg;
    logic [1:0] mult_source_reg;
    logic pll_lock, upset = 1'b0, mult_enable_reg, pll_init_reg, use_ext_src_reg;
    logic settled_reg, pad_p02_claim_reg, pad_p03_claim_reg;
    int error_cnt = 0, cmp_count = 0, seed, n;
    cmc_top cmc_top_inst (.clock, .rstn, .clk_en, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd,
        .sfr_wdata, .pll_lock, .ext_osc_mode_field, .sfr_rdata_reg, .mult_enable_reg,
        .pll_init_reg, .mult_source_reg, .use_ext_src_reg, .mult_factor_reg, .out_scale_reg,
        .settled_reg, .pad_p02_claim_reg, .pad_p03_claim_reg);
    cmc_pll_model cmc_pll_model_inst (.clock, .rstn, .enable(mult_enable_reg),
        .init(pll_init_reg), .upset, .delay(lock_dly), .locked(pll_lock));
    always #12.5 clock = ~clock;
    // Ends the run with the verdict.
    task automatic final_report;
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One write or read cycle; results are settled when it returns.
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] p,
                       input logic [7:0] v);
        @(posedge clock);
        sfr_addr <= a;
        sfr_page <= p;
        sfr_wdata <= v;
        sfr_wr <= w;
        sfr_rd <= !w;
        @(posedge clock);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        @(negedge clock);
    endtask
    function automatic logic [7:0] scale_of(input logic [7:0] v);
        return v[1] ? {5'h00, v[4:2]} : 8'h00;
    endfunction
    initial begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        final_report();
    end
    initial begin
        seed = 30809;
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        acc(1'b0, 8'h97, 8'h0F, 8'h00);
        chk("ctrl", 8'h00, sfr_rdata_reg);
        chk("factor", 8'h02, {5'h00, mult_factor_reg});
        // Random settings with init clear; bit 5 written is dropped.
        repeat (40) begin
            d = 8'($random(seed)) & 8'hBF;
            acc(1'b1, 8'h97, 8'h0F, d);
            chk("enable", {7'h00, d[7]}, {7'h00, mult_enable_reg});
            chk("source", {6'h00, d[1:0]}, {6'h00, mult_source_reg});
            chk("ext", {7'h00, d[0]}, {7'h00, use_ext_src_reg});
            chk("factor", d[1] ? 8'h04 : 8'h02, {5'h00, mult_factor_reg});
            chk("scale", scale_of(d), {5'h00, out_scale_reg});
            acc(1'b0, 8'h97, 8'h0F, 8'h00);
            chk("ctrl", d & 8'h9F, sfr_rdata_reg);
        end
        // Foreign address, foreign page and frozen clock enable are all ignored.
        acc(1'b1, 8'h98, 8'h0F, 8'hFF);
        acc(1'b1, 8'h97, 8'h00, 8'hFF);
        @(posedge clock);
        clk_en <= 1'b0;
        acc(1'b1, 8'h97, 8'h0F, 8'hFF);
        @(posedge clock);
        clk_en <= 1'b1;
        acc(1'b0, 8'h97, 8'h0F, 8'h00);
        chk("foreign", d & 8'h9F, sfr_rdata_reg);
        // The external crystal runs before it feeds the multiplier.
        @(posedge clock);
        ext_osc_mode_field <= cmc_pkg::XMODE_XTAL;
        // Bring-up with a prompt and a slow lock.
        for (int k = 0; k < 2; k++) begin
            lock_dly <= k ? 8'h3C : 8'h00;
            acc(1'b1, 8'h97, 8'h0F, 8'h00);
            acc(1'b1, 8'h97, 8'h0F, 8'h40);
            chk("init_off", 8'h00, {7'h00, pll_init_reg});
            acc(1'b1, 8'h97, 8'h0F, 8'h0B);
            acc(1'b1, 8'h97, 8'h0F, 8'h8B);
            chk("settled", 8'h00, {7'h00, settled_reg});
            repeat (cmc_pkg::SETTLE_CYC) @(posedge clock);
            acc(1'b1, 8'h97, 8'h0F, 8'hCB);
            chk("settled", 8'h01, {7'h00, settled_reg});
            chk("init_on", 8'h01, {7'h00, pll_init_reg});
            for (n = 0; n < 100 && sfr_rdata_reg[5] !== 1'b1; n++) begin
                acc(1'b0, 8'h97, 8'h0F, 8'h00);
            end
            if (n == 100) begin
                error_cnt++;
                final_report();
            end
            chk("locked", 8'hEB, sfr_rdata_reg);
            @(posedge clock);
            upset <= 1'b1;
            acc(1'b0, 8'h97, 8'h0F, 8'h00);
            acc(1'b0, 8'h97, 8'h0F, 8'h00);
            chk("unlock", 8'h00, {7'h00, sfr_rdata_reg[5]});
            @(posedge clock);
            upset <= 1'b0;
            acc(1'b1, 8'h97, 8'h0F, 8'h0B);
            acc(1'b0, 8'h97, 8'h0F, 8'h00);
            chk("off", 8'h0B, sfr_rdata_reg);
        end
        // Every oscillator mode and the pads it claims.
        for (int m = 0; m < 8; m++) begin
            @(posedge clock);
            ext_osc_mode_field <= 3'(m);
            repeat (2) @(negedge clock);
            chk("p02", {7'h00, m >= 6}, {7'h00, pad_p02_claim_reg});
            chk("p03", {7'h00, m >= 2}, {7'h00, pad_p03_claim_reg});
        end
        final_report();
    end
endmodule
`default_nettype wire

//--- verilog/cmc_pad_route.sv
`timescale 1ns/10ps
`default_nettype none
// Decides which port pins the external oscillator claims, registered.
module cmc_pad_route (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       clk_en,
    input  wire logic [2:0] ext_osc_mode_field,
    output var  logic       pad_p02_claim_reg,
    output var  logic       pad_p03_claim_reg
);
    logic p02_next;  // Next claim of the input-side pad.
    logic p03_next;  // Next claim of the output-side pad.

    // Decode the mode field into pad claims.
    always_comb begin
        p02_next = 1'b0;
        p03_next = 1'b0;
        unique case (ext_osc_mode_field)
            cmc_pkg::XMODE_XTAL, cmc_pkg::XMODE_XTAL_D2: begin
                p02_next = 1'b1;
                p03_next = 1'b1;
            end
            cmc_pkg::XMODE_CMOS, cmc_pkg::XMODE_CMOS_D2,
            cmc_pkg::XMODE_RC, cmc_pkg::XMODE_CAP: begin
                p03_next = 1'b1;
            end
            default: begin
                // Oscillator off claims nothing.
                p02_next = 1'b0;
            end
        endcase
    end

    // Register the claims.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pad_p02_claim_reg <= 1'b0;
            pad_p03_claim_reg <= 1'b0;
        end else if (clk_en) begin
            pad_p02_claim_reg <= p02_next;
            pad_p03_claim_reg <= p03_next;
        end
    end
endmodule
`default_nettype wire

//--- verilog/cmc_pkg.sv
// Summary of operation
// - Bit 7 enables the clock multiplier.
// - Writing bit 6 with bit 7 set, once enabled, starts multiplier initialization.
// - Bit 5 reads one only when locked.
// - Bits 4:2 select output scaling factor.
// - Bits 1:0 select source and base multiplication.
// - Times-two sources ignore the scaling field.
// - Register sits at 0x97 on page 0x0F.
// - Crystal mode routes P0.2 and P0.3 pads.
// - Capacitor, RC, CMOS modes use only P0.3.
// - Output is two or four times input; only times-four is scaled.
// - Mode 110 and 111 are crystal modes.
`default_nettype none
package cmc_pkg;
    // Register decode.
    localparam logic [7:0] CTRL_ADDR   = 8'h97;
    localparam logic [7:0] CTRL_PAGE   = 8'h0F;
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    // Field positions.
    localparam int EN_BIT      = 7;
    localparam int INIT_BIT    = 6;
    localparam int RDY_BIT     = 5;
    localparam int SCALE_HI    = 4;
    localparam int SCALE_LO    = 2;
    localparam int SRC_HI      = 1;
    localparam int SRC_LO      = 0;
    // Source codes.
    localparam logic [1:0] SRC_INT_X2  = 2'h0;
    localparam logic [1:0] SRC_EXT_X2  = 2'h1;
    localparam logic [1:0] SRC_INT_X4  = 2'h2;
    localparam logic [1:0] SRC_EXT_X4  = 2'h3;
    // External oscillator mode codes.
    localparam logic [2:0] XMODE_CMOS    = 3'h2;
    localparam logic [2:0] XMODE_CMOS_D2 = 3'h3;
    localparam logic [2:0] XMODE_RC      = 3'h4;
    localparam logic [2:0] XMODE_CAP     = 3'h5;
    localparam logic [2:0] XMODE_XTAL    = 3'h6;
    localparam logic [2:0] XMODE_XTAL_D2 = 3'h7;
    // Scaling code meaning factor of one.
    localparam logic [2:0] SCALE_ONE   = 3'h0;
    // Base multiplication factors presented to the multiplier.
    localparam logic [2:0] FACTOR_X2   = 3'h2;
    localparam logic [2:0] FACTOR_X4   = 3'h4;
    // Settling time after enable, in nanoseconds, and its count at 40 MHz.
    localparam int CLK_PERIOD_NS = 25;
    localparam int SETTLE_NS     = 5000;
    localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Multiplier sequencing states.
    typedef enum logic [1:0] {
        CMC_OFF     = 2'b00,
        CMC_ENABLED = 2'b01,
        CMC_LOCKING = 2'b10,
        CMC_LOCKED  = 2'b11
    } cmc_state_e;
endpackage
`default_nettype wire

//--- verilog/cmc_top.sv
`timescale 1ns/10ps
`default_nettype none
// Clock multiplier control register, lock sequencing and pad routing.
module cmc_top #(
    parameter int SETTLE_CYCLES = cmc_pkg::SETTLE_CYC  // Enable-to-init settling count, cycles.
) (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       clk_en,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_page,
    input  wire logic       sfr_wr,
    input  wire logic       sfr_rd,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       pll_lock,
    input  wire logic [2:0] ext_osc_mode_field,
    output var  logic [7:0] sfr_rdata_reg,
    output var  logic       mult_enable_reg,
    output var  logic       pll_init_reg,
    output var  logic [1:0] mult_source_reg,
    output var  logic       use_ext_src_reg,
    output var  logic [2:0] mult_factor_reg,
    output var  logic [2:0] out_scale_reg,
    output var  logic       settled_reg,
    output var  logic       pad_p02_claim_reg,
    output var  logic       pad_p03_claim_reg
);
    // Counter width that holds the whole settling count.
    localparam int CW = $clog2(SETTLE_CYCLES + 1);
    localparam logic [CW-1:0] SETTLE_LAST = CW'(SETTLE_CYCLES);

    // A settling count below one cycle leaves the counter without meaning.
    if (SETTLE_CYCLES < 1) begin : g_bad_settle
        $error("cmc_top: settling count must be at least one cycle");
    end

    // Register field storage and next values.
    logic       en_reg, en_next;         // Enable bit.
    logic       init_reg, init_next;     // Initialize bit as written.
    logic [2:0] scale_reg, scale_next;   // Output scaling field.
    logic [1:0] src_reg, src_next;       // Source field.
    logic       rdy_reg, rdy_next;       // Lock flag seen by software.
    cmc_pkg::cmc_state_e state_reg, state_next;  // Sequencer state.
    logic [CW-1:0] cnt_reg, cnt_next;    // Settling counter.
    logic [7:0] rdata_next;              // Next read data.
    logic       hit;                     // Access decodes to the register.
    logic       wr_hit;                  // Write to the register.
    logic       init_req;                // Write that starts initialization.

    // Address and page decode of the control register.
    function automatic logic decode(input logic [7:0] a, input logic [7:0] p);
        decode = (a == cmc_pkg::CTRL_ADDR) && (p == cmc_pkg::CTRL_PAGE);
    endfunction

    // Read value assembled from fields.
    function automatic logic [7:0] pack(input logic e, input logic i, input logic r,
                                        input logic [2:0] s, input logic [1:0] m);
        pack = {e, i, r, s, m};
    endfunction

    // Access decode; a write never reaches the ready bit.
    assign hit      = decode(sfr_addr, sfr_page);
    assign wr_hit   = sfr_wr && hit;
    assign init_req = wr_hit && sfr_wdata[cmc_pkg::INIT_BIT]
                      && sfr_wdata[cmc_pkg::EN_BIT];

    // Next values of fields and sequencer.
    always_comb begin
        en_next    = en_reg;
        init_next  = init_reg;
        scale_next = scale_reg;
        src_next   = src_reg;
        state_next = state_reg;
        cnt_next   = cnt_reg;
        rdy_next   = rdy_reg;
        if (wr_hit) begin
            // The ready bit is not writable.
            en_next    = sfr_wdata[cmc_pkg::EN_BIT];
            init_next  = sfr_wdata[cmc_pkg::INIT_BIT];
            scale_next = sfr_wdata[cmc_pkg::SCALE_HI:cmc_pkg::SCALE_LO];
            src_next   = sfr_wdata[cmc_pkg::SRC_HI:cmc_pkg::SRC_LO];
        end
        // Settling counter runs while enabled.
        if (!en_next) begin
            // Disabling restarts the settling time.
            cnt_next = '0;
        end else if (cnt_reg != SETTLE_LAST) begin
            // Count up and saturate at the settling count.
            cnt_next = cnt_reg + CW'(1);
        end
        unique case (state_reg)
            cmc_pkg::CMC_OFF: begin
                // Waiting for the enable bit.
                if (en_next) begin
                    state_next = cmc_pkg::CMC_ENABLED;
                end
            end
            cmc_pkg::CMC_ENABLED: begin
                // Only an initialize write, or disabling, leaves this state.
                if (init_req && en_reg) begin
                    state_next = cmc_pkg::CMC_LOCKING;
                end
            end
            cmc_pkg::CMC_LOCKING: begin
                // Initialize is held until the loop reports lock.
                if (pll_lock) begin
                    state_next = cmc_pkg::CMC_LOCKED;
                end
            end
            cmc_pkg::CMC_LOCKED: begin
                // Reinitialize or loss of lock both restart the search.
                if (init_req) begin
                    state_next = cmc_pkg::CMC_LOCKING;
                end else if (!pll_lock) begin
                    // Lost lock: search again without software help.
                    state_next = cmc_pkg::CMC_LOCKING;
                end
            end
        endcase
        // Initialize in CMC_LOCKING holds the lock search, even when lock is reported.
        if (state_reg == cmc_pkg::CMC_LOCKING && init_req) begin
            state_next = cmc_pkg::CMC_LOCKING;
        end
        if (!en_next) begin
            // Disabling overrides every state.
            state_next = cmc_pkg::CMC_OFF;
        end
        // Ready only when locked, and never in the cycle of a reinitialize.
        rdy_next = (state_next == cmc_pkg::CMC_LOCKED) && pll_lock && !init_req;
    end

    // Read data capture.
    always_comb begin
        rdata_next = sfr_rdata_reg;
        if (sfr_rd && hit) begin
            // A decoded read captures the register as it stands.
            rdata_next = pack(en_reg, init_reg, rdy_reg, scale_reg, src_reg);
        end
    end

    // Register all state.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            // Every field takes its bit of the register reset value.
            en_reg        <= cmc_pkg::CTRL_RESET[cmc_pkg::EN_BIT];
            init_reg      <= cmc_pkg::CTRL_RESET[cmc_pkg::INIT_BIT];
            scale_reg     <= cmc_pkg::CTRL_RESET[cmc_pkg::SCALE_HI:cmc_pkg::SCALE_LO];
            src_reg       <= cmc_pkg::CTRL_RESET[cmc_pkg::SRC_HI:cmc_pkg::SRC_LO];
            rdy_reg       <= cmc_pkg::CTRL_RESET[cmc_pkg::RDY_BIT];
            state_reg     <= cmc_pkg::CMC_OFF;
            cnt_reg       <= '0;
            sfr_rdata_reg <= cmc_pkg::CTRL_RESET;
        end else if (clk_en) begin
            // State moves only while the clock enable is high.
            en_reg        <= en_next;
            init_reg      <= init_next;
            scale_reg     <= scale_next;
            src_reg       <= src_next;
            rdy_reg       <= rdy_next;
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            sfr_rdata_reg <= rdata_next;
        end
    end

    // Multiplier controls presented to the analog block.
    logic       pll_init_next;   // Hold initialize while searching lock.
    logic [2:0] factor_next;     // Base multiplication factor.
    logic [2:0] oscale_next;     // Effective scaling code.
    logic       ext_next;        // External oscillator feeds the multiplier.
    logic       settled_next;    // Enable has been held for the settling time.

    // Derive the multiplier controls from the next register values.
    always_comb begin
        pll_init_next = (state_next == cmc_pkg::CMC_LOCKING);
        ext_next      = src_next[cmc_pkg::SRC_LO];
        settled_next  = en_next && (cnt_next == SETTLE_LAST);
        factor_next   = cmc_pkg::FACTOR_X2;
        oscale_next   = scale_next;
        unique case (src_next)
            cmc_pkg::SRC_INT_X2, cmc_pkg::SRC_EXT_X2: begin
                // The doubled clock passes unscaled.
                factor_next = cmc_pkg::FACTOR_X2;
                oscale_next = cmc_pkg::SCALE_ONE;
            end
            cmc_pkg::SRC_INT_X4, cmc_pkg::SRC_EXT_X4: begin
                // The quadrupled clock takes the programmed scaling.
                factor_next = cmc_pkg::FACTOR_X4;
            end
        endcase
    end

    // Register multiplier controls.
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            // Controls idle as the register does after reset.
            mult_enable_reg <= cmc_pkg::CTRL_RESET[cmc_pkg::EN_BIT];
            pll_init_reg    <= 1'b0;
            mult_source_reg <= cmc_pkg::CTRL_RESET[cmc_pkg::SRC_HI:cmc_pkg::SRC_LO];
            use_ext_src_reg <= 1'b0;
            mult_factor_reg <= cmc_pkg::FACTOR_X2;
            out_scale_reg   <= cmc_pkg::SCALE_ONE;
            settled_reg     <= 1'b0;
        end else if (clk_en) begin
            // Outputs take the next values so they never lag the register.
            mult_enable_reg <= en_next;
            pll_init_reg    <= pll_init_next;
            mult_source_reg <= src_next;
            use_ext_src_reg <= ext_next;
            mult_factor_reg <= factor_next;
            out_scale_reg   <= oscale_next;
            settled_reg     <= settled_next;
        end
    end

    // Oscillator pad claims.
    cmc_pad_route cmc_pad_route_inst (
        .clock              (clock),
        .rstn               (rstn),
        .clk_en             (clk_en),
        .ext_osc_mode_field (ext_osc_mode_field),
        .pad_p02_claim_reg  (pad_p02_claim_reg),
        .pad_p03_claim_reg  (pad_p03_claim_reg)
    );
endmodule
`default_nettype wire
